// ==== hdl/tsfir_pkg.sv ====
// package: constants and carrier types of the tape status and flag interrupt registers
package tsfir_pkg;
   // status word positions, bit 0 is the most significant bit of the 36-bit word
   localparam int unsigned WORD_W = 36;
   localparam int unsigned HALF_W = 18;
   localparam int unsigned NUM_FLAGS = 6;
   localparam int unsigned ST_ENABLE_BASE = 0;
   localparam int unsigned ST_DELAY = 6;
   localparam int unsigned ST_ACTIVE = 7;
   localparam int unsigned ST_UP_TO_SPEED = 8;
   localparam int unsigned ST_FUNC_STOP = 17;
   localparam int unsigned ST_FLAG_BASE = 18;
   // control write word positions
   localparam int unsigned CW_ENABLE_BASE = 18;
   localparam int unsigned CW_STOP_ALL = 34;
   localparam int unsigned CW_FUNC_STOP = 35;
   localparam int unsigned CW_PI_LSB = 35;
   localparam int unsigned CW_PI_MSB = 33;
   // flag index inside the flag group, flag k sits at status bit 18+k
   localparam int unsigned FL_PARITY = 0;
   localparam int unsigned FL_MISSED = 1;
   localparam int unsigned FL_DONE = 2;
   localparam int unsigned FL_ILLEGAL = 3;
   localparam int unsigned FL_END_ZONE = 4;
   localparam int unsigned FL_BLK_MISSED = 5;
   // reset values
   localparam logic [0:5] RST_ENABLES = 6'h00;
   localparam logic [0:5] RST_FLAGS = 6'h00;
   localparam logic [2:0] RST_PI_LEVEL = 3'h0;
   // timing
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned DATA_MISSED_US = 266;
   localparam int unsigned DATA_MISSED_CYCLES =
      (DATA_MISSED_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned MISS_CNT_W = 16;

   // processor i/o bus request
   typedef struct packed {
      logic cond_out;
      logic cond_in;
      logic status_sel;
      logic command_sel;
      logic [0:35] data;
   } tsfir_bus_t;

   // levels and pulses from the tape data path and transport logic
   typedef struct packed {
      logic parity_err;
      logic illegal_op;
      logic end_zone;
      logic block_missed;
      logic job_done;
      logic in_gap;
      logic op_read_data;
      logic op_write_data;
      logic block_end;
      logic data_req;
      logic data_ack;
      logic delay_wait;
      logic active;
      logic up_to_speed;
   } tsfir_path_t;

   // all state of the block
   typedef struct packed {
      logic [0:5] enables;
      logic [0:5] flags;
      logic func_stop;
      logic stop_pending;
      logic [MISS_CNT_W-1:0] miss_cnt;
      logic [2:0] pi_level;
      logic irq;
      logic [0:35] read_data;
      logic read_valid;
      logic [0:17] skip_half;
      logic stop_others;
      logic op_end;
      logic repeat_last;
      logic read_to_end;
      logic tape_stop;
   } tsfir_state_t;
endpackage

// ==== hdl/tsfir_regs.sv ====
// module: status word, flag enables, function stop and flags-channel request of the tape control
`timescale 1ns/100ps

module tsfir_regs #(
   parameter int unsigned DATA_MISSED_CYCLES = tsfir_pkg::DATA_MISSED_CYCLES
)(
   input wire logic i_sys_clk,
   input wire logic i_reset,
   input wire tsfir_pkg::tsfir_bus_t i_bus,
   input wire tsfir_pkg::tsfir_path_t i_path,
   output logic [0:35] o_read_data,
   output logic o_read_valid,
   output logic [0:17] o_skip_half,
   output logic o_flag_irq,
   output logic [2:0] o_flag_pi_level,
   output logic o_stop_others,
   output logic o_op_end,
   output logic o_repeat_last,
   output logic o_read_to_end,
   output logic o_tape_stop
);
   tsfir_pkg::tsfir_state_t st;
   tsfir_pkg::tsfir_state_t next_st;
   logic [0:5] qual;
   logic [0:5] flag_set;
   logic [0:35] status_word;
   logic wr_status;
   logic wr_command;
   logic rd_status;
   logic miss_expired;

   assign wr_status = i_bus.cond_out & i_bus.status_sel;
   assign wr_command = i_bus.cond_out & i_bus.command_sel;
   assign rd_status = i_bus.cond_in & i_bus.status_sel;
   assign miss_expired = (32'(st.miss_cnt) >= DATA_MISSED_CYCLES - 1)
      & i_path.data_req & ~i_path.data_ack;

   // per-flag qualification and status assembly
   genvar k;
   generate
      for (k = 0; k < 6; k = k + 1)
      begin : g_flag
         assign qual[k] = st.flags[k] & st.enables[k];
         assign status_word[tsfir_pkg::ST_ENABLE_BASE + k] = st.enables[k];
         assign status_word[tsfir_pkg::ST_FLAG_BASE + k] = st.flags[k];
      end
   endgenerate

   assign status_word[tsfir_pkg::ST_DELAY] = i_path.delay_wait;
   assign status_word[tsfir_pkg::ST_ACTIVE] = i_path.active;
   assign status_word[tsfir_pkg::ST_UP_TO_SPEED] = i_path.up_to_speed;
   assign status_word[9:16] = 8'h00;
   assign status_word[tsfir_pkg::ST_FUNC_STOP] = st.func_stop;
   assign status_word[24:35] = 12'h000;

   // flag set sources
   always_comb
   begin
      flag_set = 6'h00;
      flag_set[tsfir_pkg::FL_PARITY] = i_path.parity_err;
      flag_set[tsfir_pkg::FL_MISSED] = miss_expired & ~st.func_stop;
      flag_set[tsfir_pkg::FL_DONE] = i_path.job_done;
      flag_set[tsfir_pkg::FL_ILLEGAL] = i_path.illegal_op;
      flag_set[tsfir_pkg::FL_END_ZONE] = i_path.end_zone;
      flag_set[tsfir_pkg::FL_BLK_MISSED] = i_path.block_missed;
      if (wr_status & i_bus.data[tsfir_pkg::CW_FUNC_STOP] & i_path.in_gap
         & (i_path.op_read_data | i_path.op_write_data))
      begin
         flag_set[tsfir_pkg::FL_DONE] = 1'b1;
      end
      if (st.stop_pending & i_path.block_end)
      begin
         flag_set[tsfir_pkg::FL_DONE] = 1'b1;
      end
   end

   // next state
   always_comb
   begin
      next_st = st;
      next_st.read_valid = 1'b0;
      next_st.stop_others = 1'b0;
      next_st.op_end = 1'b0;
      next_st.tape_stop = i_path.end_zone;
      if (wr_command)
      begin
         next_st.enables = tsfir_pkg::RST_ENABLES;
         next_st.flags = tsfir_pkg::RST_FLAGS;
         next_st.func_stop = 1'b0;
         next_st.pi_level = i_bus.data[tsfir_pkg::CW_PI_MSB:tsfir_pkg::CW_PI_LSB];
      end
      if (wr_status)
      begin
         next_st.enables = i_bus.data[18:23];
         next_st.stop_others = i_bus.data[tsfir_pkg::CW_STOP_ALL];
         if (i_bus.data[tsfir_pkg::CW_FUNC_STOP])
         begin
            next_st.func_stop = 1'b1;
            if (i_path.in_gap)
            begin
               next_st.op_end = i_path.op_read_data | i_path.op_write_data;
            end
            else if (i_path.op_read_data | i_path.op_write_data)
            begin
               next_st.stop_pending = 1'b1;
               next_st.read_to_end = i_path.op_read_data;
               next_st.repeat_last = i_path.op_write_data;
            end
         end
      end
      if (st.stop_pending & i_path.block_end)
      begin
         next_st.stop_pending = 1'b0;
         next_st.read_to_end = 1'b0;
         next_st.repeat_last = 1'b0;
         next_st.op_end = 1'b1;
      end
      // sticky flags: a set in the same cycle as a clear wins
      next_st.flags = next_st.flags | flag_set;
      // data request watchdog
      if (i_path.data_req & ~i_path.data_ack & ~miss_expired)
      begin
         next_st.miss_cnt = st.miss_cnt + 16'h0001;
      end
      else
      begin
         next_st.miss_cnt = 16'h0000;
      end
      next_st.irq = |(next_st.flags & next_st.enables);
      if (rd_status)
      begin
         next_st.read_data = status_word;
         next_st.read_valid = 1'b1;
      end
      next_st.skip_half = status_word[18:35];
   end

   always_ff @(posedge i_sys_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign o_read_data = st.read_data;
   assign o_read_valid = st.read_valid;
   assign o_skip_half = st.skip_half;
   assign o_flag_irq = st.irq;
   assign o_flag_pi_level = st.pi_level;
   assign o_stop_others = st.stop_others;
   assign o_op_end = st.op_end;
   assign o_repeat_last = st.repeat_last;
   assign o_read_to_end = st.read_to_end;
   assign o_tape_stop = st.tape_stop;

   // checks
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   property p_irq_follows_flags;
      ##1 (o_flag_irq == |(st.flags & st.enables));
   endproperty
   a_irq_follows_flags: assert property (p_irq_follows_flags) else $error("irq mismatch");

   property p_parity_irq;
      (st.flags[0] & st.enables[0]) |-> o_flag_irq;
   endproperty
   a_parity_irq: assert property (p_parity_irq) else $error("parity irq lost");

   property p_command_clears;
      (wr_command & ~wr_status & ~|flag_set) |=> (st.flags == 6'h00 && st.enables == 6'h00
         && !st.func_stop);
   endproperty
   a_command_clears: assert property (p_command_clears) else $error("status not cleared");

   property p_pi_level;
      wr_command |=> (o_flag_pi_level == $past(i_bus.data[33:35]));
   endproperty
   a_pi_level: assert property (p_pi_level) else $error("pi level wrong");

   property p_echo;
      (wr_status & ~wr_command) |=> (st.enables == $past(i_bus.data[18:23]));
   endproperty
   a_echo: assert property (p_echo) else $error("enable echo wrong");

   property p_read_word;
      rd_status |=> (o_read_valid && o_read_data == $past(status_word));
   endproperty
   a_read_word: assert property (p_read_word) else $error("status read wrong");

   property p_stop_all;
      (wr_status & i_bus.data[34]) |=> o_stop_others ##1 !o_stop_others;
   endproperty
   a_stop_all: assert property (p_stop_all) else $error("stop all pulse wrong");

   property p_gap_stop;
      (wr_status & i_bus.data[35] & i_path.in_gap & i_path.op_read_data)
         |=> (o_op_end && st.flags[2]);
   endproperty
   a_gap_stop: assert property (p_gap_stop) else $error("gap stop failed");

   property p_no_miss_after_stop;
      (st.func_stop & ~st.flags[1] & ~wr_command) |=> !st.flags[1];
   endproperty
   a_no_miss_after_stop: assert property (p_no_miss_after_stop) else $error("missed set");

   property p_block_end_done;
      (st.stop_pending & i_path.block_end & ~wr_command) |=> (o_op_end && st.flags[2]
         && !o_repeat_last && !o_read_to_end);
   endproperty
   a_block_end_done: assert property (p_block_end_done) else $error("block end done");

   property p_end_zone;
      i_path.end_zone |=> (o_tape_stop && st.flags[4]);
   endproperty
   a_end_zone: assert property (p_end_zone) else $error("end zone not handled");

   property p_miss_irq;
      (st.flags[1] & st.enables[1]) |-> o_flag_irq;
   endproperty
   a_miss_irq: assert property (p_miss_irq) else $error("missed irq lost");

   property p_done_irq;
      (st.flags[2] & st.enables[2]) |-> o_flag_irq;
   endproperty
   a_done_irq: assert property (p_done_irq) else $error("done irq lost");

   property p_illegal_irq;
      (st.flags[3] & st.enables[3]) |-> o_flag_irq;
   endproperty
   a_illegal_irq: assert property (p_illegal_irq) else $error("illegal irq lost");

   property p_zone_irq;
      (st.flags[4] & st.enables[4]) |-> o_flag_irq;
   endproperty
   a_zone_irq: assert property (p_zone_irq) else $error("end zone irq lost");

   property p_blk_miss_irq;
      (st.flags[5] & st.enables[5]) |-> o_flag_irq;
   endproperty
   a_blk_miss_irq: assert property (p_blk_miss_irq) else $error("block irq lost");

   property p_irq_quiet;
      (~|qual) |-> !o_flag_irq;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("irq without flag");

   property p_stop_all_cause;
      o_stop_others |-> $past(wr_status & i_bus.data[34]);
   endproperty
   a_stop_all_cause: assert property (p_stop_all_cause) else $error("stray stop all");

   property p_read_to_end;
      (wr_status & i_bus.data[35] & ~i_path.in_gap & i_path.op_read_data & ~st.stop_pending)
         |=> o_read_to_end;
   endproperty
   a_read_to_end: assert property (p_read_to_end) else $error("read to end missing");

   property p_repeat_last;
      (wr_status & i_bus.data[35] & ~i_path.in_gap & i_path.op_write_data & ~st.stop_pending)
         |=> o_repeat_last;
   endproperty
   a_repeat_last: assert property (p_repeat_last) else $error("repeat missing");

   property p_read_to_end_holds;
      (o_read_to_end & ~i_path.block_end & ~wr_status) |=> o_read_to_end;
   endproperty
   a_read_to_end_holds: assert property (p_read_to_end_holds) else $error("read end lost");

   property p_repeat_holds;
      (o_repeat_last & ~i_path.block_end & ~wr_status) |=> o_repeat_last;
   endproperty
   a_repeat_holds: assert property (p_repeat_holds) else $error("repeat lost");

   property p_skip_half;
      1'b1 |=> (o_skip_half == $past(status_word[18:35]));
   endproperty
   a_skip_half: assert property (p_skip_half) else $error("skip half wrong");

   property p_delay_bit;
      rd_status |=> (o_read_data[6] == $past(i_path.delay_wait));
   endproperty
   a_delay_bit: assert property (p_delay_bit) else $error("delay bit wrong");

   property p_active_bit;
      rd_status |=> (o_read_data[7] == $past(i_path.active));
   endproperty
   a_active_bit: assert property (p_active_bit) else $error("active bit wrong");

   property p_speed_bit;
      rd_status |=> (o_read_data[8] == $past(i_path.up_to_speed));
   endproperty
   a_speed_bit: assert property (p_speed_bit) else $error("speed bit wrong");

   property p_miss_not_early;
      (~st.flags[1] & (32'(st.miss_cnt) < DATA_MISSED_CYCLES - 1)) |=> !st.flags[1];
   endproperty
   a_miss_not_early: assert property (p_miss_not_early) else $error("missed too early");

   property p_missed_kept;
      (st.flags[1] & ~wr_command) |=> st.flags[1];
   endproperty
   a_missed_kept: assert property (p_missed_kept) else $error("missed flag lost");

   property p_read_pulse;
      o_read_valid |-> $past(rd_status);
   endproperty
   a_read_pulse: assert property (p_read_pulse) else $error("stray read valid");

   property p_tape_stop_cause;
      o_tape_stop |-> $past(i_path.end_zone);
   endproperty
   a_tape_stop_cause: assert property (p_tape_stop_cause) else $error("stray tape stop");

   property p_op_end_cause;
      o_op_end |-> $past((wr_status & i_bus.data[35] & i_path.in_gap)
         | (st.stop_pending & i_path.block_end));
   endproperty
   a_op_end_cause: assert property (p_op_end_cause) else $error("stray op end");

   property p_pi_stable;
      ~wr_command |=> $stable(o_flag_pi_level);
   endproperty
   a_pi_stable: assert property (p_pi_stable) else $error("pi level moved");
endmodule

// ==== bench/tsfir_host.sv ====
// host processor model driving the conditions strobes of the i/o bus
`timescale 1ns/100ps
module tsfir_host (
   input wire logic i_sys_clk,
   output tsfir_pkg::tsfir_bus_t o_bus
);
   initial o_bus = '0;
   // one-cycle strobe; released data shows the inverse so stale values cannot pass
   task automatic xfer(input logic rd, input logic st, input logic [0:35] d);
      @(posedge i_sys_clk);
      o_bus <= {~rd, rd, st, ~st, d};
      @(posedge i_sys_clk);
      o_bus <= {4'h0, ~d};
   endtask
endmodule

// ==== bench/tsfir_regs_tb.sv ====
// self-checking bench of the tape status and flag interrupt registers
`timescale 1ns/100ps
module tsfir_regs_tb;
   localparam int unsigned MISS = 20;
   logic i_sys_clk;
   logic i_reset;
   tsfir_pkg::tsfir_bus_t bus;
   tsfir_pkg::tsfir_path_t path;
   logic [0:35] o_read_data;
   logic [0:17] o_skip_half;
   logic [2:0] o_flag_pi_level;
   logic o_read_valid, o_flag_irq, o_stop_others, o_op_end;
   logic o_repeat_last, o_read_to_end, o_tape_stop;
   int fail_count = 0;
   int tests_run = 0;
   logic [0:35] exp_q[$];
   logic [0:5] en, fl;
   logic [0:2] live;
   logic fs;
   logic [0:35] d;

   tsfir_regs #(.DATA_MISSED_CYCLES(MISS)) tsfir_regs_inst (
      .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_bus(bus), .i_path(path),
      .o_read_data(o_read_data), .o_read_valid(o_read_valid), .o_skip_half(o_skip_half),
      .o_flag_irq(o_flag_irq), .o_flag_pi_level(o_flag_pi_level),
      .o_stop_others(o_stop_others), .o_op_end(o_op_end), .o_repeat_last(o_repeat_last),
      .o_read_to_end(o_read_to_end), .o_tape_stop(o_tape_stop));
   tsfir_host tsfir_host_inst (.i_sys_clk(i_sys_clk), .o_bus(bus));

   initial
   begin
      i_sys_clk = 1'b0;
      forever #2.5 i_sys_clk = ~i_sys_clk;
   end

   task automatic check(input logic [0:35] got, input logic [0:35] want);
      tests_run++;
      if (got !== want)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, want);
      end
   endtask

   function automatic logic [0:35] sw();
      return {en, live, 8'h00, fs, fl, 12'h000};
   endfunction

   // read results are compared as they appear
   always @(posedge i_sys_clk)
      if (o_read_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check(o_read_data, ~o_read_data);
         else
            check(o_read_data, exp_q.pop_front());
      end

   task automatic rd();
      exp_q.push_back(sw());
      tsfir_host_inst.xfer(1'b1, 1'b1, 36'h000000000);
      repeat (2) @(posedge i_sys_clk);
      check(o_skip_half, {fl, 12'h000});
   endtask

   task automatic stat(input logic [0:35] w);
      tsfir_host_inst.xfer(1'b0, 1'b1, w);
      #1;
   endtask

   task automatic cmd();
      d = 36'({$urandom, $urandom});
      tsfir_host_inst.xfer(1'b0, 1'b0, d);
      en = '0;
      fl = '0;
      fs = 1'b0;
      #1;
      check(o_flag_pi_level, d[33:35]);
   endtask

   task automatic flag_pulse(input int k);
      @(posedge i_sys_clk);
      case (k)
         0: path.parity_err <= 1'b1;
         2: path.job_done <= 1'b1;
         3: path.illegal_op <= 1'b1;
         4: path.end_zone <= 1'b1;
         5: path.block_missed <= 1'b1;
         default: path.data_req <= 1'b1;
      endcase
      repeat (k == 1 ? MISS : 1) @(posedge i_sys_clk);
      {path.parity_err, path.job_done, path.illegal_op} <= 3'h0;
      {path.end_zone, path.block_missed, path.data_req} <= 3'h0;
      #1;
   endtask

   task automatic finish_test();
      $display("tests %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      #100us;
      fail_count++;
      finish_test();
   end

   initial
   begin
      void'($urandom(32'h74cf4ee2));
      path = '0;
      i_reset = 1'b1;
      {en, fl, live, fs} = '0;
      repeat (20) @(posedge i_sys_clk);
      i_reset <= 1'b0;
      rd();
      for (int k = 0; k < 6; k++)
      begin
         live = 3'($urandom);
         @(posedge i_sys_clk);
         {path.delay_wait, path.active, path.up_to_speed} <= live;
         cmd();
         d = '0;
         d[18 + k] = 1'b1;
         stat(d);
         en[k] = 1'b1;
         check(o_flag_irq, 1'b0);
         flag_pulse(k);
         fl[k] = 1'b1;
         check(o_flag_irq, 1'b1);
         check(o_tape_stop, k == 4);
         rd();
         stat(36'h000000000);
         en = '0;
         check(o_flag_irq, 1'b0);
      end
      $display("test enables and flags done");
      for (int m = 0; m < 3; m++)
      begin
         cmd();
         @(posedge i_sys_clk);
         path.op_read_data <= m != 2;
         path.op_write_data <= m == 2;
         path.in_gap <= m == 0;
         if (m == 2)
         begin
            flag_pulse(1);
            fl[1] = 1'b1;
         end
         stat(36'h000000001);
         fs = 1'b1;
         check(o_op_end, m == 0);
         check(o_read_to_end, m == 1);
         check(o_repeat_last, m == 2);
         flag_pulse(1);
         if (m != 0)
         begin
            @(posedge i_sys_clk);
            path.block_end <= 1'b1;
            @(posedge i_sys_clk);
            path.block_end <= 1'b0;
            #1;
            check(o_op_end, 1'b1);
            check({o_read_to_end, o_repeat_last}, 2'b00);
         end
         fl[2] = 1'b1;
         rd();
         {path.op_read_data, path.op_write_data, path.in_gap} <= 3'h0;
      end
      $display("test function stop done");
      stat(36'h000000002);
      check(o_stop_others, 1'b1);
      @(posedge i_sys_clk);
      #1;
      check(o_stop_others, 1'b0);
      cmd();
      // a conditions-in on the command device gets no answer; a stray valid is a mismatch
      tsfir_host_inst.xfer(1'b1, 1'b0, 36'h000000000);
      repeat (2) @(posedge i_sys_clk);
      rd();
      $display("test stop all and clear done");
      finish_test();
   end
endmodule
